/* rtl/shp_port.sv */
`timescale 1ns/1ps
module shp_port
	import shp_pkg::*;
#(
	parameter int unsigned LINK_CLK_HZ = LINK_CLK_HZ_DEF
) (
	input  wire logic              clk,
	input  wire logic              srst,
	input  wire logic [ADDR_W-1:0] io_addr,
	input  wire logic              io_wr,
	input  wire logic              io_rd,
	input  wire logic [7:0]        io_wdata,
	output logic      [7:0]        io_rdata,
	input  wire logic [1:0]        frame_length_field,
	input  wire logic              manual_select_ctrl,
	input  wire logic              manual_select_level,
	input  wire logic              peripheral_irq_input_n,
	output logic      [3:0]        irq_line_out,
	input  wire logic              link_clk,
	output logic                   sclk,
	output logic                   mosi,
	input  wire logic              miso,
	output logic                   ss_n
);

	typedef struct packed {
		logic [7:0]  status;
		logic [31:0] data;
		logic [1:0]  len;
		logic        busy;
		logic        start_tgl;
		logic        done_seen;
		logic [7:0]  rdata;
		logic [3:0]  irq;
	} shp_bus_t;

	typedef struct packed {
		shp_link_state_t state;
		logic [7:0]      half;
		logic [7:0]      div_cnt;
		logic [4:0]      bit_cnt;
		logic [31:0]     word;
		logic [1:0]      len;
		logic            order;
		logic            start_seen;
		logic            done_tgl;
		logic            ss_auto;
		logic            sclk;
		logic            mosi;
		logic            ss_n;
	} shp_link_t;

	shp_bus_t  br_reg;
	shp_bus_t  br_next;
	shp_link_t lr_reg;
	shp_link_t lr_next;

	logic       link_rst;
	logic       pend_s;
	logic [1:0] len_s;
	logic       done_s;
	logic       start_s;
	logic       miso_s;
	logic       man_s;
	logic       man_lvl_s;
	logic       start_now;
	logic [4:0] lo_bit;

	function automatic logic [7:0] half_of(input logic [1:0] r);
		int unsigned f;
		int unsigned h;
		unique case (r)
			2'd0: f = RATE_HZ_0;
			2'd1: f = RATE_HZ_1;
			2'd2: f = RATE_HZ_2;
			2'd3: f = RATE_HZ_3;
		endcase
		// nominal rates are rounded: allow one percent above them
		h = (LINK_CLK_HZ + 2 * f - 1 - (2 * f) / 100) / (2 * f);
		return h[7:0];
	endfunction

	// lowest frame bit: frames grow downward from bit 31
	function automatic logic [4:0] low_of(input logic [1:0] l);
		return {2'd3 - l, 3'b000};
	endfunction

	function automatic logic [31:0] shift_of(
		input logic [31:0] w,
		input logic [4:0]  lo,
		input logic        right,
		input logic        rx
	);
		logic [31:0] t;
		logic [31:0] res;
		if (right) begin
			t = {rx, w[31:1]};
		end else begin
			t     = {w[30:0], 1'b0};
			t[lo] = rx;
		end
		for (int i = 0; i < 32; i++) begin
			res[i] = (i >= int'(lo)) ? t[i] : w[i];
		end
		return res;
	endfunction

	initial begin
		// two link cycles per half period cover the miso synchroniser
		if (half_of(2'd3) < 8'd2) $error("shp_port: link clock too slow");
		if ((LINK_CLK_HZ + 2 * RATE_HZ_0 - 1) / (2 * RATE_HZ_0) > 255) begin
			$error("shp_port: link clock too fast for divider");
		end
	end

	// crossings into the bus clock
	shp_sync #(.W(4)) u_sync_bus (
		.clk (clk),
		.rst (srst),
		.d   ({~peripheral_irq_input_n, frame_length_field, lr_reg.done_tgl}),
		.q   ({pend_s, len_s, done_s})
	);

	// reset for the link side, no reset of its own
	shp_sync #(.W(1)) u_sync_rst (
		.clk (link_clk),
		.rst (1'b0),
		.d   (srst),
		.q   (link_rst)
	);

	shp_sync #(.W(4)) u_sync_link (
		.clk (link_clk),
		.rst (link_rst),
		.d   ({br_reg.start_tgl, miso, manual_select_ctrl, manual_select_level}),
		.q   ({start_s, miso_s, man_s, man_lvl_s})
	);

	// ---------------- bus clock side ----------------
	always_comb begin
		br_next = br_reg;
		if (io_rd) begin
			unique case (io_addr)
				ADDR_STATUS: begin
					// R5: pending mirrors interrupt input
					// R6: busy flag readback
					br_next.rdata = {br_reg.status[7:2], pend_s, br_reg.busy};
				end
				ADDR_BYTE0: br_next.rdata = br_reg.data[7:0];
				ADDR_BYTE1: br_next.rdata = br_reg.data[15:8];
				ADDR_BYTE2: br_next.rdata = br_reg.data[23:16];
				ADDR_BYTE3: br_next.rdata = br_reg.data[31:24];
				default:    br_next.rdata = RDATA_IDLE;
			endcase
		end
		if (io_wr) begin
			unique case (io_addr)
				ADDR_STATUS: begin
					// R5: low two bits stay read-only
					br_next.status = {io_wdata[7:2], 2'b00};
				end
				// R7: byte registers, top is most significant
				ADDR_BYTE0: if (!br_reg.busy) br_next.data[7:0] = io_wdata;
				ADDR_BYTE1: if (!br_reg.busy) br_next.data[15:8] = io_wdata;
				ADDR_BYTE2: if (!br_reg.busy) br_next.data[23:16] = io_wdata;
				ADDR_BYTE3: begin
					// R8: top byte write launches transfer
					if (!br_reg.busy) begin
						br_next.data[31:24] = io_wdata;
						br_next.start_tgl   = ~br_reg.start_tgl;
						br_next.busy        = 1'b1;
						br_next.len         = len_s;
					end
				end
				default: ;
			endcase
		end
		// R14: busy drops once the frame has ended
		if (done_s != br_reg.done_seen) begin
			br_next.done_seen = done_s;
			br_next.busy      = 1'b0;
			br_next.data      = lr_reg.word;
		end
		// R1: one-hot line from selector
		// R2: gated by enable
		if (br_reg.status[POS_IRQ_EN] && pend_s) begin
			br_next.irq = IRQ_ONEHOT_BASE << br_reg.status[POS_IRQ_SEL +: 2];
		end else begin
			br_next.irq = IRQ_NONE;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			br_reg        <= '0;
			br_reg.status <= STATUS_RESET;
			br_reg.data   <= DATA_RESET;
		end else begin
			br_reg <= br_next;
		end
	end

	assign io_rdata     = br_reg.rdata;
	assign irq_line_out = br_reg.irq;

	// ---------------- link clock side ----------------
	assign start_now = (start_s != lr_reg.start_seen);
	assign lo_bit    = low_of(lr_reg.len);

	always_comb begin
		lr_next = lr_reg;
		unique case (lr_reg.state)
			L_IDLE: begin
				lr_next.sclk = 1'b0;
				if (start_now) begin
					lr_next.start_seen = start_s;
					lr_next.word       = br_reg.data;
					lr_next.len        = br_reg.len;
					lr_next.order      = br_reg.status[POS_ORDER];
					// R3: divider from rate field
					lr_next.half       = half_of(br_reg.status[POS_RATE +: 2]);
					lr_next.div_cnt    = half_of(br_reg.status[POS_RATE +: 2]) - 8'd1;
					lr_next.bit_cnt    = 5'd0;
					// R9: automatic select for the frame
					lr_next.ss_auto    = 1'b1;
					// R4: first bit per shift order
					// R10: frame spans bit 31 down to low_of(len)
					if (br_reg.status[POS_ORDER]) begin
						lr_next.mosi = br_reg.data[low_of(br_reg.len)];
					end else begin
						lr_next.mosi = br_reg.data[31];
					end
					lr_next.state = L_SETUP;
				end
			end
			L_SETUP, L_LOW: begin
				if (lr_reg.div_cnt == 8'd0) begin
					lr_next.sclk    = 1'b1;
					lr_next.div_cnt = lr_reg.half - 8'd1;
					lr_next.state   = L_HIGH;
				end else begin
					lr_next.div_cnt = lr_reg.div_cnt - 8'd1;
				end
			end
			L_HIGH: begin
				if (lr_reg.div_cnt == 8'd0) begin
					lr_next.sclk    = 1'b0;
					// R11: left shift, receive into frame lsb
					// R12: right shift, receive into bit 31
					// sampled just before the fall, past the synchroniser lag
					lr_next.word    = shift_of(lr_reg.word, lo_bit, lr_reg.order, miso_s);
					lr_next.mosi    = lr_reg.order ? lr_next.word[lo_bit] : lr_next.word[31];
					lr_next.bit_cnt = lr_reg.bit_cnt + 5'd1;
					lr_next.div_cnt = lr_reg.half - 8'd1;
					// R14: stop after 8*(len+1) bits
					if (lr_reg.bit_cnt == {lr_reg.len, 3'b111}) begin
						lr_next.state = L_TAIL;
					end else begin
						lr_next.state = L_LOW;
					end
				end else begin
					lr_next.div_cnt = lr_reg.div_cnt - 8'd1;
				end
			end
			L_TAIL: begin
				if (lr_reg.div_cnt == 8'd0) begin
					lr_next.ss_auto = 1'b0;
					// R13: right-mode result moved to low bytes
					if (lr_reg.order) begin
						lr_next.word = lr_reg.word >> lo_bit;
					end
					lr_next.done_tgl = ~lr_reg.done_tgl;
					lr_next.state    = L_IDLE;
				end else begin
					lr_next.div_cnt = lr_reg.div_cnt - 8'd1;
				end
			end
			default: lr_next.state = L_IDLE;
		endcase
		// R9: manual control overrides automatic select
		lr_next.ss_n = man_s ? ~man_lvl_s : ~lr_next.ss_auto;
	end

	always_ff @(posedge link_clk) begin
		if (link_rst) begin
			lr_reg       <= '0;
			lr_reg.state <= L_IDLE;
			lr_reg.ss_n  <= 1'b1;
		end else begin
			lr_reg <= lr_next;
		end
	end

	assign sclk = lr_reg.sclk;
	assign mosi = lr_reg.mosi;
	assign ss_n = lr_reg.ss_n;

	// ---------------- checks ----------------
	AST_IRQ_ROUTE: assert property (@(posedge clk) disable iff (srst) // R1
		br_reg.status[POS_IRQ_EN] && pend_s |=>
		irq_line_out == (IRQ_ONEHOT_BASE << $past(br_reg.status[7:6])))
		else $error("interrupt routed to wrong line");

	AST_IRQ_GATE: assert property (@(posedge clk) disable iff (srst) // R2
		!br_reg.status[POS_IRQ_EN] |=> irq_line_out == IRQ_NONE)
		else $error("interrupt driven while disabled");

	AST_RATE_DIV: assert property (@(posedge link_clk) disable iff (link_rst) // R3
		lr_reg.state == L_IDLE && start_now |=>
		lr_reg.half == half_of($past(br_reg.status[5:4])) && lr_reg.half != 8'd0)
		else $error("divider does not match rate field");

	AST_PEND_READ: assert property (@(posedge clk) disable iff (srst) // R5
		io_rd && io_addr == ADDR_STATUS |=> io_rdata[1] == $past(pend_s))
		else $error("pending flag readback wrong");

	AST_BUSY_READ: assert property (@(posedge clk) disable iff (srst) // R6
		io_rd && io_addr == ADDR_STATUS |=> io_rdata[0] == $past(br_reg.busy))
		else $error("busy flag readback wrong");

	AST_START: assert property (@(posedge clk) disable iff (srst) // R8
		io_wr && io_addr == ADDR_BYTE3 && !br_reg.busy |=>
		br_reg.busy && br_reg.start_tgl != $past(br_reg.start_tgl))
		else $error("top byte write did not start transfer");

	AST_MSB_FIRST: assert property (@(posedge link_clk) disable iff (link_rst) // R11
		lr_reg.state == L_SETUP && !lr_reg.order |-> mosi == lr_reg.word[31])
		else $error("left mode first bit wrong");

	AST_LSB_FIRST: assert property (@(posedge link_clk) disable iff (link_rst) // R12
		lr_reg.state == L_SETUP && lr_reg.order |-> mosi == lr_reg.word[lo_bit])
		else $error("right mode first bit wrong");

	AST_AUTO_SELECT: assert property (@(posedge link_clk) disable iff (link_rst) // R9
		lr_reg.ss_auto && !$past(man_s) |-> !ss_n)
		else $error("automatic select not asserted");

	AST_REALIGN: assert property (@(posedge link_clk) disable iff (link_rst) // R13
		lr_reg.state == L_TAIL && lr_reg.div_cnt == 8'd0 && lr_reg.order |=>
		lr_reg.word == ($past(lr_reg.word) >> $past(lo_bit)))
		else $error("right mode result not moved down");

	AST_DONE: assert property (@(posedge clk) disable iff (srst) // R14
		br_reg.busy && done_s != br_reg.done_seen |=> !br_reg.busy)
		else $error("busy stuck after frame end");

endmodule

/* shared/shp_pkg.sv */
// How it works
// R1: two-bit selector routes interrupt to IRQ3/4/5/10
// R2: interrupt driven only while enable D3 set
// R3: rate field picks one of four clocks
// R4: order bit D2: 0 left/MSB, 1 right/LSB
// R5: D1 mirrors peripheral interrupt, read-only
// R6: D0 busy while serial clock shifts data
// R7: four data bytes, highest address most significant
// R8: writing top byte last starts the clock
// R9: automatic select asserted when manual control clear
// R10: wider frames extend downward from top byte
// R11: left mode sends top MSB, receives frame LSB
// R12: right mode sends frame LSB, receives top MSB
// R13: right mode result lands at low bytes
// R14: length 8-32 bits, busy clears after last
package shp_pkg;

	localparam int unsigned ADDR_W = 10;

	localparam logic [9:0] ADDR_STATUS = 10'h1E9;
	localparam logic [9:0] ADDR_BYTE0  = 10'h1EA;
	localparam logic [9:0] ADDR_BYTE1  = 10'h1EB;
	localparam logic [9:0] ADDR_BYTE2  = 10'h1EC;
	localparam logic [9:0] ADDR_BYTE3  = 10'h1ED;

	// status field positions
	localparam int unsigned POS_IRQ_SEL = 6;
	localparam int unsigned POS_RATE    = 4;
	localparam int unsigned POS_IRQ_EN  = 3;
	localparam int unsigned POS_ORDER   = 2;
	localparam int unsigned POS_PENDING = 1;
	localparam int unsigned POS_BUSY    = 0;

	localparam logic [7:0]  STATUS_RESET = 8'h00;
	localparam logic [31:0] DATA_RESET   = 32'h0000_0000;
	localparam logic [7:0]  RDATA_IDLE   = 8'h00;

	// serial clock rates, in Hz
	localparam int unsigned RATE_HZ_0 = 1042000;
	localparam int unsigned RATE_HZ_1 = 2083000;
	localparam int unsigned RATE_HZ_2 = 4167000;
	localparam int unsigned RATE_HZ_3 = 8333000;

	// link clock in the bench: 48 ns period
	localparam int unsigned LINK_CLK_HZ_DEF = 20833333;

	// one-hot interrupt line: bit0 IRQ3, bit1 IRQ4, bit2 IRQ5, bit3 IRQ10
	localparam logic [3:0] IRQ_ONEHOT_BASE = 4'h1;
	localparam logic [3:0] IRQ_NONE        = 4'h0;

	typedef enum logic [2:0] {
		L_IDLE  = 3'b000,
		L_SETUP = 3'b001,
		L_HIGH  = 3'b010,
		L_LOW   = 3'b011,
		L_TAIL  = 3'b100
	} shp_link_state_t;

endpackage

/* rtl/shp_sync.sv */
`timescale 1ns/1ps
module shp_sync
	import shp_pkg::*;
#(
	parameter int unsigned W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} shp_sync_t;

	shp_sync_t st_reg;
	shp_sync_t st_next;

	initial begin
		if (W < 1) $error("shp_sync: width must be at least one");
	end

	always_comb begin
		st_next    = st_reg;
		st_next.s1 = d;
		st_next.s2 = st_reg.s1;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign q = st_reg.s2;

endmodule

/* bench/shp_peer_model.sv */
`timescale 1ns/1ps
module shp_peer_model (
	input  wire logic        sclk,
	input  wire logic        mosi,
	input  wire logic        ss_n,
	input  wire logic [31:0] reply,
	output logic             miso,
	output logic [31:0]      rx_word,
	output int               rx_count,
	output int               sclk_period
);
	logic [31:0] tx_sr;
	realtime     t_last;
	initial begin
		miso = 1'b0;
		rx_word = 32'h0000_0000;
		rx_count = 0;
		sclk_period = 0;
		t_last = 0;
	end
	always @(negedge ss_n) begin
		tx_sr = reply;
		rx_word = 32'h0000_0000;
		rx_count = 0;
		miso = reply[31];
	end
	always @(posedge sclk) if (!ss_n) begin
		rx_word = {rx_word[30:0], mosi};
		rx_count++;
		sclk_period = int'($realtime - t_last);
		t_last = $realtime;
	end
	always @(negedge sclk) if (!ss_n) begin
		tx_sr = tx_sr << 1;
		miso = tx_sr[31];
	end
	// released line shows no stale bit
	always @(posedge ss_n) miso = ~miso;
endmodule

/* bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top
	import shp_pkg::*;
;
	logic              clk = 1'b0;
	logic              link_clk = 1'b0;
	logic              srst = 1'b1;
	logic [ADDR_W-1:0] io_addr = '0;
	logic              io_wr = 1'b0;
	logic              io_rd = 1'b0;
	logic [7:0]        io_wdata = 8'h00;
	logic [7:0]        io_rdata;
	logic [1:0]        frame_length_field = 2'd0;
	logic              manual_select_ctrl = 1'b0;
	logic              manual_select_level = 1'b0;
	logic              peripheral_irq_input_n = 1'b1;
	logic [3:0]        irq_line_out;
	logic              sclk;
	logic              mosi;
	logic              miso;
	logic              ss_n;
	logic [31:0]       reply = 32'h0000_0000;
	logic [31:0]       rx_word;
	int                rx_count;
	int                sclk_period;
	int                fail_count = 0;
	int                cmp_count = 0;

	always #5 clk = ~clk;
	// offset keeps the link clock out of phase
	initial #7 forever #24 link_clk = ~link_clk;

	shp_port uut (.clk(clk), .srst(srst), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
		.io_wdata(io_wdata), .io_rdata(io_rdata), .frame_length_field(frame_length_field),
		.manual_select_ctrl(manual_select_ctrl), .manual_select_level(manual_select_level),
		.peripheral_irq_input_n(peripheral_irq_input_n), .irq_line_out(irq_line_out),
		.link_clk(link_clk), .sclk(sclk), .mosi(mosi), .miso(miso), .ss_n(ss_n));
	shp_peer_model peer (.sclk(sclk), .mosi(mosi), .ss_n(ss_n), .reply(reply), .miso(miso),
		.rx_word(rx_word), .rx_count(rx_count), .sclk_period(sclk_period));

	task automatic summarize;
		if (fail_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", nm, e, g);
			fail_count++;
		end
	endtask
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge clk);
		io_addr <= a;
		io_wdata <= d;
		io_wr <= 1'b1;
		@(posedge clk);
		io_wr <= 1'b0;
	endtask
	task automatic rd(input logic [9:0] a, output logic [7:0] d);
		@(posedge clk);
		io_addr <= a;
		io_rd <= 1'b1;
		@(posedge clk);
		io_rd <= 1'b0;
		@(posedge clk);
		d = io_rdata;
	endtask
	task automatic wait_idle;
		logic [7:0] s;
		int         n;
		for (n = 0; n < 2000; n++) begin
			rd(ADDR_STATUS, s);
			if (s[0] === 1'b0) break;
		end
		if (n == 2000) begin
			fail_count++;
			summarize();
		end
	endtask
	task automatic reset_test;
		logic [7:0] b;
		int         i;
		for (i = 0; i < 5; i++) begin
			rd(10'(ADDR_STATUS + i), b);
			chk("reset value", 32'h0000_0000, b);
		end
		wr(10'h1EE, 8'hFF);
		rd(10'h1EE, b);
		chk("unmapped", 32'h0000_0000, b);
	endtask
	task automatic irq_test;
		logic [7:0] s;
		int         k;
		peripheral_irq_input_n <= 1'b0;
		repeat (6) @(posedge clk);
		chk("irq disabled", 32'h0000_0000, irq_line_out);
		for (k = 0; k < 4; k++) begin
			wr(ADDR_STATUS, {2'(k), 6'b00_1011});
			repeat (4) @(posedge clk);
			chk("irq line", 32'(1 << k), irq_line_out);
			rd(ADDR_STATUS, s);
			chk("status", {2'(k), 6'b00_1010}, s);
		end
		peripheral_irq_input_n <= 1'b1;
		repeat (6) @(posedge clk);
		chk("irq released", 32'h0000_0000, irq_line_out);
		rd(ADDR_STATUS, s);
		chk("pending clear", 32'h0000_0000, s[1]);
		wr(ADDR_STATUS, 8'h00);
	endtask
	task automatic manual_test;
		manual_select_ctrl <= 1'b1;
		manual_select_level <= 1'b1;
		repeat (20) @(posedge clk);
		chk("manual select", 32'h0000_0000, ss_n);
		manual_select_level <= 1'b0;
		repeat (20) @(posedge clk);
		chk("manual release", 32'h0000_0001, ss_n);
		manual_select_ctrl <= 1'b0;
		repeat (20) @(posedge clk);
	endtask
	task automatic xfer(input logic [1:0] len, input logic ord, input logic [1:0] rate,
		input logic [31:0] data, input logic [31:0] rep);
		logic [7:0]  b;
		logic [31:0] got;
		logic [31:0] exp_tx;
		logic [31:0] exp_rx;
		int          n;
		int          i;
		n = 8 * (len + 1);
		frame_length_field <= len;
		reply <= rep;
		wr(ADDR_STATUS, {2'b00, rate, 1'b0, ord, 2'b00});
		for (i = 0; i < 3; i++) wr(10'(ADDR_BYTE0 + i), data[8*i+:8]);
		wr(ADDR_BYTE3, data[31:24]);
		rd(ADDR_STATUS, b);
		chk("busy", 32'h0000_0001, b[0]);
		wr(ADDR_BYTE0, ~data[7:0]);
		wr(ADDR_BYTE3, 8'h00);
		rd(ADDR_BYTE0, b);
		chk("refused write", data[7:0], b);
		wait_idle();
		chk("bit count", 32'(n), rx_count);
		chk("sclk period", 32'(96 * (rate == 0 ? 10 : rate == 1 ? 5 : rate == 2 ? 3 : 2)),
			sclk_period);
		exp_tx = 32'h0000_0000;
		exp_rx = ord ? 32'h0000_0000 : data;
		for (i = 0; i < n; i++) begin
			if (ord) begin
				exp_tx[i] = data[31-i];
				exp_rx[i] = rep[31-i];
			end else begin
				exp_tx[i] = data[32-n+i];
				exp_rx[32-n+i] = rep[32-n+i];
			end
		end
		chk("sent bits", exp_tx, rx_word);
		for (i = 0; i < 4; i++) begin
			rd(10'(ADDR_BYTE0 + i), b);
			got[8*i+:8] = b;
		end
		chk("received", exp_rx, got);
	endtask

	initial begin
		repeat (25) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		reset_test();
		irq_test();
		manual_test();
		xfer(2'd0, 1'b0, 2'd3, 32'hA5C3_0F1E, 32'h9600_0000);
		xfer(2'd1, 1'b1, 2'd2, 32'h3C5A_E187, 32'hB2D4_0000);
		xfer(2'd2, 1'b0, 2'd1, 32'h1234_5678, 32'hC3A5_9E00);
		xfer(2'd3, 1'b1, 2'd0, 32'h8421_F00D, 32'h5AF0_C369);
		xfer(2'd2, 1'b1, 2'd3, 32'h0F1E_2D3C, 32'hE17B_4800);
		summarize();
	end
endmodule
